// ### rtl/rpm_pkg.sv
package rpm_pkg;

	// ********************************************************
	// Register offsets and field positions
	// ********************************************************
	localparam logic [7:0] ADDR_TGT      = 8'h00;
	localparam logic [7:0] ADDR_RST      = 8'h01;
	localparam logic [7:0] ADDR_STS      = 8'h04;
	localparam logic [7:0] ADDR_CSI_PAGE = 8'h32;
	localparam logic [7:0] ADDR_RX_PAGE  = 8'h4c;
	localparam logic [7:0] CSI_LO        = 8'h33;
	localparam logic [7:0] CSI_HI        = 8'h3a;
	localparam logic [7:0] AEQ_LO        = 8'h40;
	localparam logic [7:0] AEQ_HI        = 8'h45;
	localparam logic [7:0] RX_LO         = 8'h46;
	localparam logic [7:0] RX_HI         = 8'h7f;
	localparam logic [7:0] CSIDBG_LO     = 8'h90;
	localparam logic [7:0] CSIDBG_HI     = 8'h9f;
	localparam logic [7:0] IND_LO        = 8'hb0;
	localparam logic [7:0] IND_HI        = 8'hbf;
	localparam logic [7:0] RXDBG_LO      = 8'hd0;
	localparam logic [7:0] RXDBG_HI      = 8'hdf;
	localparam logic [7:0] RXID_LO       = 8'hf0;
	localparam logic [7:0] RXID_HI       = 8'hf5;
	localparam logic [7:0] PORTI2C_LO    = 8'hf8;
	localparam logic [7:0] PORTI2C_HI    = 8'hfb;
	localparam int TGT_OVR_BIT   = 0;
	localparam int RST_LOGIC_BIT = 0;
	localparam int RST_FULL_BIT  = 1;
	localparam int RST_ROM_BIT   = 2;
	localparam int STS_DONE_BIT  = 6;
	localparam int STS_CKSUM_BIT = 7;
	localparam int CSI_WR_BIT    = 0;
	localparam int CSI_RD_BIT    = 4;

	// ********************************************************
	// Reset values and timing
	// ********************************************************
	localparam logic [7:0] CSI_PAGE_RST = 8'h01;
	localparam logic [7:0] RX_PAGE_RST  = 8'h0f;
	localparam int CLK_NS           = 25;
	localparam int SOFT_RST_NS      = 200;
	localparam int SOFT_RST_CYC     = (SOFT_RST_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [3:0] SOFT_RST_CNT = 4'(SOFT_RST_CYC);
	localparam logic [1:0] STRAP_SETTLE = 2'h3;

	// ********************************************************
	// Types
	// ********************************************************
	typedef enum logic [2:0] {
		RG_SHARED = 3'h0,
		RG_CSI    = 3'h1,
		RG_RX     = 3'h2,
		RG_RXDBG  = 3'h3,
		RG_RSVD   = 3'h4,
		RG_LOCAL  = 3'h5
	} rpm_region_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_EXT  = 2'h1,
		ST_ANS  = 2'h2
	} rpm_state_e;

	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rpm_req_s;

	typedef struct packed {
		logic       valid;
		logic       src;
		logic [7:0] rdata;
	} rpm_rsp_s;

	typedef struct packed {
		logic        valid;
		logic        write;
		rpm_region_e region;
		logic [1:0]  rd_sel;
		logic [3:0]  wr_mask;
		logic [7:0]  addr;
		logic [7:0]  wdata;
	} rpm_ext_s;

endpackage

// ### rtl/rpm_addr_decode.sv
`timescale 1ns/10ps
// Sorts an 8-bit register address into its region of the map
module rpm_addr_decode (
	input  wire logic [7:0]          addr,   // Register address
	output rpm_pkg::rpm_region_e     region  // Region it falls in
);

	// ********************************************************
	// Range decode
	// ********************************************************
	// Page selectors and the reset, status and address registers live here
	always_comb begin
		if (addr == rpm_pkg::ADDR_TGT || addr == rpm_pkg::ADDR_RST ||
		    addr == rpm_pkg::ADDR_STS || addr == rpm_pkg::ADDR_CSI_PAGE ||
		    addr == rpm_pkg::ADDR_RX_PAGE)
			region = rpm_pkg::RG_LOCAL;
		else if (addr < rpm_pkg::ADDR_CSI_PAGE)
			region = rpm_pkg::RG_SHARED;
		else if (addr >= rpm_pkg::CSI_LO && addr <= rpm_pkg::CSI_HI)
			region = rpm_pkg::RG_CSI;
		else if (addr >= rpm_pkg::AEQ_LO && addr <= rpm_pkg::AEQ_HI)
			region = rpm_pkg::RG_SHARED;
		else if (addr >= rpm_pkg::RX_LO && addr <= rpm_pkg::RX_HI)
			region = rpm_pkg::RG_RX;
		else if ((addr >= rpm_pkg::CSIDBG_LO && addr <= rpm_pkg::CSIDBG_HI) ||
		         (addr >= rpm_pkg::IND_LO && addr <= rpm_pkg::IND_HI) ||
		         (addr >= rpm_pkg::RXID_LO && addr <= rpm_pkg::RXID_HI) ||
		         (addr >= rpm_pkg::PORTI2C_LO && addr <= rpm_pkg::PORTI2C_HI))
			region = rpm_pkg::RG_SHARED;
		else if (addr >= rpm_pkg::RXDBG_LO && addr <= rpm_pkg::RXDBG_HI)
			region = rpm_pkg::RG_RXDBG;
		else
			region = rpm_pkg::RG_RSVD;
	end

endmodule // rpm_addr_decode

// ### rtl/rpm_regmap.sv
`timescale 1ns/10ps
// Functional notes
// - Local target port and every link control channel reach all registers.
// - 0x33-0x3A: transmitter page, read if 0x32[4]=0, write if 0x32[0]=1.
// - 0x46-0x7F: rx page; reads port 0x4C[5:4], writes all set in 0x4C[3:0].
// - 0xD0-0xDF use same 0x4C read select and write enables as the rx page.
// - 0x00[7:1] shows the live address, the read-only strap while bit 0 is 0.
// - With 0x00 bit 0 set, the field is writable and is the answered address.
// - 0x01 bit 2 restarts the ROM load, self-clears; init done marks the end.
// - 0x01 bit 1 resets logic and all registers to defaults, self-clears.
// - 0x01 bit 0 resets logic, keeps registers, self-clears; 0 does nothing.
// - The init-done flag in 0x04 is set when the fuse ROM load has finished.
module rpm_regmap (
	input  wire logic             clock,             // 40 MHz clock
	input  wire logic             nrst,              // Async reset, active low
	input  rpm_pkg::rpm_req_s     loc_req,           // Local target port access
	input  rpm_pkg::rpm_req_s     link_req,          // Control channel access
	output rpm_pkg::rpm_rsp_s     rsp,               // Answer, src 0 local 1 link
	output rpm_pkg::rpm_ext_s     ext,               // Access to paged/shared banks
	input  wire logic [7:0]       ext_rdata,         // Read data from those banks
	input  wire logic [6:0]       strap_addr,        // Address strap pins
	input  wire logic             rom_done,          // ROM load finished, pulse
	input  wire logic             rom_cksum_ok,      // ROM checksum good
	output logic [6:0]            own_target_address, // Answered address
	output logic                  logic_reset,       // Digital logic reset
	output logic                  rom_reload_request, // Start ROM load, pulse
	output logic                  init_done          // ROM load complete
);

	// ********************************************************
	// State
	// ********************************************************
	typedef struct packed {
		rpm_pkg::rpm_state_e  st;
		rpm_pkg::rpm_region_e region;
		logic                 issued;
		rpm_pkg::rpm_rsp_s    rsp;
		rpm_pkg::rpm_ext_s    ext;
		logic [6:0]           strap_s1;
		logic [6:0]           strap_s2;
		logic [6:0]           strap_val;
		logic [1:0]           strap_cnt;
		logic                 strap_done;
		logic [6:0]           prog_addr;
		logic                 override;
		logic [6:0]           own_addr;
		logic [7:0]           page_csi;
		logic [7:0]           page_rx;
		logic [3:0]           rst_cnt;
		logic                 logic_rst;
		logic                 rom_req;
		logic                 done;
		logic                 cksum;
	} rpm_state_s;

	rpm_state_s           st_reg;
	rpm_state_s           st_next;
	rpm_pkg::rpm_req_s    req;
	rpm_pkg::rpm_region_e dec_region;
	logic                 take;
	logic                 take_src;

	// ********************************************************
	// Arbitration and decode
	// ********************************************************
	// Local port wins a tie; the loser waits holding its request
	assign take_src = !loc_req.valid;
	assign req      = take_src ? link_req : loc_req;
	assign take     = st_reg.st == rpm_pkg::ST_IDLE && st_reg.strap_done &&
	                  st_reg.rst_cnt == 4'h0 &&
	                  (loc_req.valid || link_req.valid);

	rpm_addr_decode rpm_addr_decode_inst (
		.addr   (req.addr),
		.region (dec_region)
	);

	// ********************************************************
	// Next state
	// ********************************************************
	always_comb begin
		st_next = st_reg;
		st_next.rsp.valid = 1'b0;
		st_next.rom_req = 1'b0;
		st_next.ext.valid = 1'b0;
		// Second stage is the only reader of the first
		st_next.strap_s1 = strap_addr;
		st_next.strap_s2 = st_reg.strap_s1;
		// Catch the strap once the synchroniser has settled, then load ROM
		if (!st_reg.strap_done) begin
			if (st_reg.strap_cnt == rpm_pkg::STRAP_SETTLE) begin
				st_next.strap_done = 1'b1;
				st_next.strap_val = st_reg.strap_s2;
				st_next.rom_req = 1'b1;
				st_next.done = 1'b0;
			end else begin
				st_next.strap_cnt = st_reg.strap_cnt + 2'h1;
			end
		end
		if (st_reg.rst_cnt != 4'h0)
			st_next.rst_cnt = st_reg.rst_cnt - 4'h1;
		unique case (st_reg.st)
			rpm_pkg::ST_IDLE: begin
				if (take) begin
					st_next.region = dec_region;
					st_next.rsp.src = take_src;
					st_next.rsp.rdata = 8'h00;
					st_next.ext.write = req.write;
					st_next.ext.region = dec_region;
					st_next.ext.addr = req.addr;
					st_next.ext.wdata = req.wdata;
					st_next.ext.rd_sel = 2'h0;
					st_next.ext.wr_mask = 4'h1;
					st_next.issued = 1'b1;
					unique case (dec_region)
						rpm_pkg::RG_CSI: begin
							// Only port 0 exists in this page
							st_next.issued = req.write ?
								st_reg.page_csi[rpm_pkg::CSI_WR_BIT] :
								!st_reg.page_csi[rpm_pkg::CSI_RD_BIT];
						end
						rpm_pkg::RG_RX, rpm_pkg::RG_RXDBG: begin
							st_next.ext.rd_sel = st_reg.page_rx[5:4];
							st_next.ext.wr_mask = st_reg.page_rx[3:0];
							st_next.issued = !req.write ||
								st_reg.page_rx[3:0] != 4'h0;
						end
						rpm_pkg::RG_SHARED: st_next.issued = 1'b1;
						default: st_next.issued = 1'b0;
					endcase
					if (dec_region == rpm_pkg::RG_LOCAL) begin
						st_next.issued = 1'b0;
						st_next.st = rpm_pkg::ST_ANS;
						st_next.rsp.valid = 1'b1;
						if (req.write) begin
							unique case (req.addr)
								rpm_pkg::ADDR_TGT: begin
									st_next.override = req.wdata[rpm_pkg::TGT_OVR_BIT];
									if (req.wdata[rpm_pkg::TGT_OVR_BIT])
										st_next.prog_addr = req.wdata[7:1];
								end
								rpm_pkg::ADDR_RST: begin
									if (req.wdata[rpm_pkg::RST_FULL_BIT]) begin
										// Defaults back, logic held, ROM reloaded
										st_next.override = 1'b0;
										st_next.prog_addr = 7'h00;
										st_next.page_csi = rpm_pkg::CSI_PAGE_RST;
										st_next.page_rx = rpm_pkg::RX_PAGE_RST;
										st_next.rst_cnt = rpm_pkg::SOFT_RST_CNT;
										st_next.rom_req = 1'b1;
										st_next.done = 1'b0;
									end else if (req.wdata[rpm_pkg::RST_LOGIC_BIT]) begin
										st_next.rst_cnt = rpm_pkg::SOFT_RST_CNT;
									end
									if (req.wdata[rpm_pkg::RST_ROM_BIT]) begin
										st_next.rom_req = 1'b1;
										st_next.done = 1'b0;
									end
								end
								rpm_pkg::ADDR_CSI_PAGE: st_next.page_csi = req.wdata;
								rpm_pkg::ADDR_RX_PAGE:  st_next.page_rx = req.wdata;
								default: ;
							endcase
						end else begin
							unique case (req.addr)
								rpm_pkg::ADDR_TGT:
									st_next.rsp.rdata = {st_reg.own_addr,
									                     st_reg.override};
								rpm_pkg::ADDR_STS:
									st_next.rsp.rdata = {st_reg.cksum,
									                     st_reg.done, 6'h00};
								rpm_pkg::ADDR_CSI_PAGE:
									st_next.rsp.rdata = st_reg.page_csi;
								rpm_pkg::ADDR_RX_PAGE:
									st_next.rsp.rdata = st_reg.page_rx;
								// Self-clearing reset bits always read zero
								default: st_next.rsp.rdata = 8'h00;
							endcase
						end
					end else begin
						st_next.st = rpm_pkg::ST_EXT;
						st_next.ext.valid = st_next.issued;
					end
				end
			end
			rpm_pkg::ST_EXT: begin
				// Banks answer in the cycle the access is presented
				st_next.rsp.valid = 1'b1;
				st_next.rsp.rdata = (st_reg.issued && !st_reg.ext.write) ?
				                    ext_rdata : 8'h00;
				st_next.st = rpm_pkg::ST_ANS;
			end
			rpm_pkg::ST_ANS: st_next.st = rpm_pkg::ST_IDLE;
			default: st_next.st = rpm_pkg::ST_IDLE;
		endcase
		// Load completion wins over a clear in the same cycle
		if (rom_done) begin
			st_next.done = 1'b1;
			st_next.cksum = rom_cksum_ok;
		end
		st_next.own_addr = st_next.override ? st_next.prog_addr :
		                   st_next.strap_val;
		st_next.logic_rst = st_next.rst_cnt != 4'h0;
	end

	// ********************************************************
	// Registers
	// ********************************************************
	// Strap value is caught on the fourth clock after release, not by reset
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			st_reg <= '0;
			st_reg.page_csi <= rpm_pkg::CSI_PAGE_RST;
			st_reg.page_rx <= rpm_pkg::RX_PAGE_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rsp                = st_reg.rsp;
	assign ext                = st_reg.ext;
	assign own_target_address = st_reg.own_addr;
	assign logic_reset        = st_reg.logic_rst;
	assign rom_reload_request = st_reg.rom_req;
	assign init_done          = st_reg.done;

	// ********************************************************
	// Checks
	// ********************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	AST_EXT_ANSWER: assert property (ext.valid |=> rsp.valid)
		else $error("Bank access not answered next cycle");
	AST_CSI_GATE: assert property (ext.valid && ext.region ==
		rpm_pkg::RG_CSI |-> (ext.write ? st_reg.page_csi[0] :
		!st_reg.page_csi[4]))
		else $error("Transmitter page reached while disabled");
	AST_RX_MASK: assert property (ext.valid && ext.region ==
		rpm_pkg::RG_RX |-> ext.wr_mask == st_reg.page_rx[3:0] &&
		ext.rd_sel == st_reg.page_rx[5:4])
		else $error("Receive page select mismatch");
	AST_RXDBG_SEL: assert property (ext.valid && ext.region ==
		rpm_pkg::RG_RXDBG |-> ext.rd_sel == st_reg.page_rx[5:4] &&
		ext.wr_mask == st_reg.page_rx[3:0])
		else $error("Debug page select mismatch");
	AST_RSVD_ZERO: assert property (rsp.valid && st_reg.region ==
		rpm_pkg::RG_RSVD |-> rsp.rdata == 8'h00 && !$past(ext.valid))
		else $error("Reserved access leaked");
	AST_ADDR_STRAP: assert property (st_reg.strap_done &&
		!st_reg.override |-> own_target_address == st_reg.strap_val)
		else $error("Address does not follow strap");
	AST_ADDR_OVR: assert property (take && req.write && dec_region ==
		rpm_pkg::RG_LOCAL && req.addr == 8'h00 && req.wdata[0]
		|=> own_target_address == $past(req.wdata[7:1]))
		else $error("Programmed address not taken");
	AST_ROM_RELOAD: assert property (take && req.write && req.addr ==
		8'h01 && req.wdata[2] |=> rom_reload_request ##1
		!rom_reload_request)
		else $error("ROM reload not a single pulse");
	AST_DONE_CAUSE: assert property ($rose(init_done) |->
		$past(rom_done))
		else $error("Init done set without ROM completion");
	AST_FULL_RST: assert property (take && req.write && req.addr ==
		8'h01 && req.wdata[1] |=> logic_reset[*8] ##1 !logic_reset)
		else $error("Full reset pulse length wrong");
	AST_LOGIC_RST: assert property (take && req.write && req.addr ==
		8'h01 && req.wdata[0] && !req.wdata[1] |=> logic_reset &&
		$stable(st_reg.page_rx) && $stable(st_reg.override))
		else $error("Logic reset disturbed registers");

	COV_LINK_EXT: cover property (ext.valid && rsp.src ##1 rsp.valid);
	COV_RX_BCAST: cover property (ext.valid && ext.wr_mask == 4'hf &&
		ext.write);
	COV_OVERRIDE: cover property ($rose(st_reg.override));
	COV_RELOAD: cover property (rom_reload_request ##[1:50] init_done);

endmodule // rpm_regmap

// ### dv/rpm_bank_model.sv
`timescale 1ns/10ps
// ********************************
// Bank and ROM loader stand-in
// ********************************
module rpm_bank_model #(
	parameter int ROM_LAT = 5 // Cycles from reload to done
) (
	input  wire logic         clock,       // Clock
	input  wire logic         nrst,        // Reset, active low
	input  rpm_pkg::rpm_ext_s ext,         // Bank access
	output logic [7:0]        ext_rdata,   // Bank read data
	input  wire logic         reload,      // ROM reload pulse
	output logic              rom_done,    // ROM load done pulse
	output logic              rom_cksum_ok // Checksum good
);
	logic [7:0] shr [256];
	logic [7:0] csi [256];
	logic [7:0] rxp [4][256];
	logic [7:0] last = 8'h00;
	int         cnt;
	int         loads;
	// Idle bus shows the inverse of the last byte, so stale reads show
	always_comb begin
		case (ext.region)
			rpm_pkg::RG_SHARED: ext_rdata = shr[ext.addr];
			rpm_pkg::RG_CSI:    ext_rdata = csi[ext.addr];
			rpm_pkg::RG_RX,
			rpm_pkg::RG_RXDBG:  ext_rdata = rxp[ext.rd_sel][ext.addr];
			default:            ext_rdata = 8'h00;
		endcase
		if (!ext.valid)
			ext_rdata = ~last;
	end
	// Writes land on every port whose enable is set
	always @(posedge clock) begin
		if (ext.valid) begin
			last <= ext_rdata;
			if (ext.write && ext.region == rpm_pkg::RG_SHARED)
				shr[ext.addr] <= ext.wdata;
			if (ext.write && ext.region == rpm_pkg::RG_CSI)
				csi[ext.addr] <= ext.wdata;
			for (int p = 0; p < 4; p++)
				if (ext.write && ext.wr_mask[p] && (ext.region ==
				    rpm_pkg::RG_RX || ext.region == rpm_pkg::RG_RXDBG))
					rxp[p][ext.addr] <= ext.wdata;
		end
	end
	// Load time is short on purpose; only the handshake matters
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cnt <= 0;
			rom_done <= 1'b0;
			loads <= 0;
		end else begin
			rom_done <= (cnt == 1);
			if (reload) begin
				cnt <= ROM_LAT;
				loads <= loads + 1;
			end else if (cnt != 0)
				cnt <= cnt - 1;
		end
	end
	// Second load reports a bad checksum, so status bit 7 must follow it
	assign rom_cksum_ok = (loads != 2);
endmodule // rpm_bank_model

// ### dv/rpm_regmap_tb_top.sv
`timescale 1ns/10ps
module rpm_regmap_tb_top;
	localparam logic [6:0] STRAP = 7'h3d;
	localparam logic [7:0] ID0 = {STRAP, 1'b0};
	localparam logic [6:0] STRAP2 = 7'h12;
	logic [6:0]        strap_pin = STRAP;
	logic              clock = 1'b0;
	logic              nrst = 1'b0;
	rpm_pkg::rpm_req_s loc_req = '0;
	rpm_pkg::rpm_req_s link_req = '0;
	rpm_pkg::rpm_rsp_s rsp;
	rpm_pkg::rpm_ext_s ext;
	logic [7:0]        ext_rdata;
	logic              rom_done;
	logic              rom_cksum_ok;
	logic [6:0]        own;
	logic              logic_reset;
	logic              reload;
	logic              init_done;
	int                mismatches = 0;
	int                checked = 0;
	int                reloads = 0;
	// ********************************
	// Clock, design and bank model
	// ********************************
	always #12.5 clock = ~clock;
	always @(posedge clock)
		if (reload === 1'b1)
			reloads <= reloads + 1;
	rpm_regmap rpm_regmap_inst (.clock(clock), .nrst(nrst),
		.loc_req(loc_req), .link_req(link_req), .rsp(rsp), .ext(ext),
		.ext_rdata(ext_rdata), .strap_addr(strap_pin), .rom_done(rom_done),
		.rom_cksum_ok(rom_cksum_ok), .own_target_address(own),
		.logic_reset(logic_reset), .rom_reload_request(reload),
		.init_done(init_done));
	rpm_bank_model rpm_bank_model_inst (.clock(clock), .nrst(nrst),
		.ext(ext), .ext_rdata(ext_rdata), .reload(reload),
		.rom_done(rom_done), .rom_cksum_ok(rom_cksum_ok));
	// ********************************
	// Shared tasks
	// ********************************
	task automatic conclude();
		if (mismatches == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic stall();
		mismatches++;
		$display("mismatch %0t wait ran out", $time);
		conclude();
	endtask
	// Valid is held until the answer, then dropped in that cycle
	task automatic access(input logic lk, input logic w,
		input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		rpm_pkg::rpm_req_s r;
		int n;
		r = '{valid: 1'b1, write: w, addr: a, wdata: d};
		@(negedge clock);
		if (lk)
			link_req = r;
		else
			loc_req = r;
		for (n = 0; n < 40 && rsp.valid !== 1'b1; n++)
			@(negedge clock);
		if (n == 40)
			stall();
		q = rsp.rdata;
		cmp({7'h0, rsp.src}, {7'h0, lk});
		loc_req = '0;
		link_req = '0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d,
		input logic lk = 1'b0);
		logic [7:0] q;
		access(lk, 1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e,
		input logic lk = 1'b0);
		logic [7:0] q;
		access(lk, 1'b0, a, 8'h00, q);
		cmp(q, e);
	endtask
	task automatic wait_init();
		int n;
		for (n = 0; n < 40 && init_done !== 1'b1; n++)
			@(negedge clock);
		if (n == 40)
			stall();
	endtask
	// Counts the cycles logic_reset stays high, first one already seen
	task automatic rst_len(output int n);
		for (n = 1; n < 30 && logic_reset === 1'b1; n++)
			@(negedge clock);
		n = n - 1;
	endtask
	// ********************************
	// Scenarios
	// ********************************
	task automatic t_reset();
		wait_init();
		rd(8'h04, 8'hc0);
		rd(8'h00, ID0);
		cmp({1'b0, own}, {1'b0, STRAP});
		rd(8'h32, rpm_pkg::CSI_PAGE_RST);
		rd(8'h4c, rpm_pkg::RX_PAGE_RST);
	endtask
	task automatic t_addr();
		wr(8'h00, 8'hab);
		cmp({1'b0, own}, 8'h55);
		rd(8'h00, 8'hab, 1'b1);
		wr(8'h00, 8'h22);
		rd(8'h00, ID0);
		cmp({1'b0, own}, {1'b0, STRAP});
	endtask
	task automatic t_rx();
		wr(8'h50, 8'ha5, 1'b1);
		wr(8'hd3, 8'h5a, 1'b1);
		for (int p = 0; p < 4; p++) begin
			wr(8'h4c, 8'(p << 4));
			rd(8'h50, 8'ha5, 1'b1);
			rd(8'hd3, 8'h5a);
		end
		wr(8'h4c, 8'h02);
		wr(8'h50, 8'h11);
		rd(8'h50, 8'ha5);
		wr(8'h4c, 8'h12);
		rd(8'h50, 8'h11);
		wr(8'h4c, 8'h20);
		wr(8'h50, 8'h99);
		rd(8'h50, 8'ha5);
	endtask
	task automatic t_csi();
		wr(8'h32, 8'h01);
		wr(8'h35, 8'h77);
		rd(8'h35, 8'h77);
		wr(8'h32, 8'h11);
		rd(8'h35, 8'h00);
		wr(8'h32, 8'h00);
		wr(8'h35, 8'h12);
		wr(8'h32, 8'h01);
		rd(8'h35, 8'h77);
	endtask
	task automatic t_shared();
		logic [7:0] rsv [6] = '{8'h3b, 8'h85, 8'ha7, 8'hc4, 8'he9, 8'hfd};
		wr(8'h4c, 8'h30);
		wr(8'h32, 8'h10);
		wr(8'h41, 8'h3c);
		rd(8'h41, 8'h3c);
		wr(8'hf9, 8'h6e, 1'b1);
		rd(8'hf9, 8'h6e, 1'b1);
		foreach (rsv[i]) begin
			wr(rsv[i], 8'hff);
			rd(rsv[i], 8'h00);
		end
	endtask
	task automatic t_soft();
		int n;
		int r0;
		wr(8'h4c, 8'h21);
		wr(8'h00, 8'hab);
		r0 = reloads;
		wr(8'h01, 8'h01);
		rst_len(n);
		cmp(8'(n), 8'(rpm_pkg::SOFT_RST_CYC));
		cmp(8'(reloads - r0), 8'h00);
		rd(8'h4c, 8'h21);
		rd(8'h00, 8'hab);
		rd(8'h01, 8'h00);
		wr(8'h01, 8'h00);
		cmp({7'h0, logic_reset}, 8'h00);
		wr(8'h01, 8'h04);
		cmp({7'h0, init_done}, 8'h00);
		@(negedge clock);
		cmp(8'(reloads - r0), 8'h01);
		wait_init();
		rd(8'h04, 8'h40);
		rd(8'h01, 8'h00);
		wr(8'h01, 8'h02);
		rst_len(n);
		cmp(8'(n), 8'(rpm_pkg::SOFT_RST_CYC));
		rd(8'h4c, rpm_pkg::RX_PAGE_RST);
		rd(8'h00, ID0);
		rd(8'h01, 8'h00);
	endtask
	// Power up again on other straps; the early read must wait, not be lost
	task automatic t_repower();
		@(negedge clock);
		strap_pin = STRAP2;
		nrst = 1'b0;
		repeat (3) @(negedge clock);
		cmp({1'b0, own}, 8'h00);
		cmp({7'h0, init_done}, 8'h00);
		nrst = 1'b1;
		rd(8'h00, {STRAP2, 1'b0});
		cmp({1'b0, own}, {1'b0, STRAP2});
		rd(8'h4c, rpm_pkg::RX_PAGE_RST);
		rd(8'h32, rpm_pkg::CSI_PAGE_RST);
		wait_init();
		rd(8'h04, 8'hc0);
	endtask
	initial begin
		repeat (8) @(negedge clock);
		nrst = 1'b1;
		t_reset();
		t_addr();
		t_rx();
		t_csi();
		t_shared();
		t_soft();
		t_repower();
		conclude();
	end
endmodule // rpm_regmap_tb_top
